// ### hw/ssdr_consts.vh
`ifndef SSDR_CONSTS_VH
`define SSDR_CONSTS_VH

// Register offsets on the internal register port.
`define SSDR_CFG2_ADDR     8'h90
`define SSDR_REV_ADDR      8'h91
`define SSDR_ID_ADDR       8'h92
`define SSDR_STATUS_ADDR   8'h93
`define SSDR_CLR_LO_ADDR   8'h94
`define SSDR_CLR_HI_ADDR   8'h95
`define SSDR_RED_LO_ADDR   8'h96
`define SSDR_RED_HI_ADDR   8'h97
`define SSDR_GRN_LO_ADDR   8'h98
`define SSDR_GRN_HI_ADDR   8'h99
`define SSDR_BLU_LO_ADDR   8'h9a
`define SSDR_BLU_HI_ADDR   8'h9b
`define SSDR_PROX_ADDR     8'h9c
`define SSDR_NE_OFS_ADDR   8'h9d

// Status flag positions.
`define SSDR_CLR_SAT_BIT   7
`define SSDR_PG_SAT_BIT    6
`define SSDR_PROX_IRQ_BIT  5
`define SSDR_LIGHT_IRQ_BIT 4
`define SSDR_BURST_IRQ_BIT 3
`define SSDR_GEST_IRQ_BIT  2
`define SSDR_PROX_VALID_FLAG_BIT    1
`define SSDR_LIGHT_VALID_FLAG_BIT    0

// Configuration register two fields.
`define SSDR_PROX_SAT_IRQ_ENABLE_BIT     7
`define SSDR_CLEAR_SAT_IRQ_ENABLE_BIT    6
`define SSDR_CFG2_RST      8'h01

// Identification fields.
`define SSDR_ID_MSB        7
`define SSDR_ID_LSB        2
`define SSDR_VID_CORE      2'h0
`define SSDR_VID_1V8       2'h2
`define SSDR_REV_RSVD      5'h00
`define SSDR_SIGN_BIT      7

`endif

// ### hw/ssdr_regs.v
`timescale 1ns/10ps
`include "ssdr_consts.vh"

// What this block does
// - Clear saturation flag sets on full range; clears on command or light disable.
// - Clear saturation flag interrupts only with its enable set.
// - Proximity/gesture saturation flag sticky until proximity clear or disable.
// - Proximity saturation flag interrupts only with its enable set.
// - Proximity interrupt flag drives interrupt only with proximity irq enable.
// - Light interrupt flag drives interrupt only while light engine enabled.
// - Burst flag mirrors its copy; interrupts only with burst enable.
// - Gesture flag sets on level above threshold or valid at mode fall.
// - Gesture flag clears only when the host has emptied the FIFO.
// - Proximity valid sets on cycle done; proximity data read clears it.
// - Light valid sets on cycle done; any colour data read restarts it.
// - Low byte read outside a locked set copies high byte into shadow read next.
// - Clear low byte read latches all eight colour bytes together.
// - Proximity result is an unsigned read-only byte.
// - North/east offset is sign/magnitude, -127 to +127.
// - North/east offset drives the NE correction output, converted to two's complement.
// - Identification register is read-only with fixed 6-bit code above.
// - Low identification bits report bus voltage: 00 core, 10 for 1.8 V.
// - Revision register gives die revision in three low bits.
// - Status register is read-only; writes do not touch flags.
// - Config two: bit 7 proximity, bit 6 clear saturation irq enable.
module ssdr_regs #(
  parameter [5:0] DEV_ID_CODE = 6'h2a, // Arbitrary identification value.
  parameter [2:0] DIE_REV     = 3'h1   // Arbitrary revision value.
) (
  input  wire        SYS_CLK_I,          // System clock, 250 MHz.
  input  wire        RST_N_I,            // Asynchronous reset, active low.
  input  wire [7:0]  REG_ADDR_I,         // Register address.
  input  wire        REG_RD_I,           // Read strobe, one cycle.
  input  wire        REG_WR_I,           // Write strobe, one cycle.
  input  wire [7:0]  REG_WDATA_I,        // Write data.
  output reg  [7:0]  REG_RDATA_O,        // Read data.
  output reg         REG_RVALID_O,       // Read data valid pulse.
  input  wire        BUS_1V8_I,          // Strap: bus runs at 1.8 V.
  input  wire        CLEAR_SAT_EVENT_I,  // Clear photodiode at full range.
  input  wire        PROX_SAT_EVENT_I,   // Analog saturation in prox cycle.
  input  wire        CLEAR_CHANNEL_IRQ_CLEAR_CMD_I, // Clear command pulse.
  input  wire        PROX_IRQ_CLEAR_CMD_I, // Proximity clear command pulse.
  input  wire        LIGHT_ENGINE_ENABLE_I, // Light engine enable.
  input  wire        PROX_ENGINE_ENABLE_I,  // Proximity engine enable.
  input  wire        PROX_IRQ_ENABLE_I,  // Proximity interrupt enable.
  input  wire        BURST_IRQ_ENABLE_I, // Burst interrupt enable.
  input  wire        GESTURE_IRQ_ENABLE_I, // Gesture interrupt enable.
  input  wire        PROX_IRQ_FLAG_I,    // Proximity threshold flag.
  input  wire        LIGHT_IRQ_FLAG_I,   // Light threshold flag.
  input  wire        BURST_IRQ_FLAG_COPY_I, // Burst flag held elsewhere.
  input  wire [5:0]  GESTURE_FIFO_LEVEL_I, // Gesture FIFO fill level.
  input  wire [5:0]  GESTURE_FIFO_THRESHOLD_I, // Gesture FIFO threshold.
  input  wire        GESTURE_VALID_FLAG_I, // Gesture data valid.
  input  wire        GESTURE_MODE_BIT_I, // Gesture mode active.
  input  wire        GESTURE_FIFO_EMPTIED_I, // Host read FIFO to empty.
  input  wire        PROX_CYCLE_DONE_I,  // Proximity cycle done pulse.
  input  wire        LIGHT_CYCLE_DONE_I, // Light cycle done pulse.
  input  wire [15:0] CLEAR_DATA_I,       // Live clear result.
  input  wire [15:0] RED_DATA_I,         // Live red result.
  input  wire [15:0] GREEN_DATA_I,       // Live green result.
  input  wire [15:0] BLUE_DATA_I,        // Live blue result.
  input  wire [7:0]  PROXIMITY_RESULT_I, // Live proximity result.
  output reg  [7:0]  NE_CORRECTION_O,    // Two's complement NE correction.
  output reg         INT_O               // Interrupt, active high.
);

  // Sign/magnitude to two's complement; negative zero maps to zero. The
  // magnitude never exceeds seven bits, so the negation cannot overflow
  // and the result stays inside -127 to +127.
  function [7:0] sm_to_tc;
    input [7:0] sm;
    begin
      if (sm[`SSDR_SIGN_BIT]) begin
        sm_to_tc = 8'h00 - {1'b0, sm[6:0]};
      end else begin
        sm_to_tc = {1'b0, sm[6:0]};
      end
    end
  endfunction

  // Colour channel index of an address inside the result block. Only the
  // pair index matters, so the low address bit is dropped; outside the
  // block the index means nothing and every user gates it first.
  function [1:0] chan_of;
    input [7:0] a;
    reg   [7:0] d;
    begin
      d = a - `SSDR_CLR_LO_ADDR;
      chan_of = d[2:1];
    end
  endfunction

  // True for any colour result address, low or high byte; the block is
  // contiguous, so two compares cover it.
  function in_colour;
    input [7:0] a;
    begin
      in_colour = (a >= `SSDR_CLR_LO_ADDR) && (a <= `SSDR_BLU_HI_ADDR);
    end
  endfunction

  // Stored state: reset retiming, flags, configuration and colour snapshot.
  reg        rst_meta;
  reg        rst_n;
  reg        strap_done;
  reg        bus_1v8;
  reg        clear_sat_flag;
  reg        prox_gest_sat_flag;
  reg        gesture_irq_flag;
  reg        prox_valid_flag;
  reg        light_valid_flag;
  reg        mode_prev;
  reg        set_locked;
  reg [7:0]  cfg2;
  reg [7:0]  north_east_offset;
  reg [63:0] snap;
  reg [7:0]  next_rdata;
  // Decoded strobes and combinational images.
  wire       rd_clr_lo;
  wire       rd_colour;
  wire       rd_lo;
  wire       rd_prox;
  wire [1:0] rd_chan;
  wire [63:0] live;
  wire [7:0] status;
  wire       gest_set;
  wire       irq_any;

  // Reset release through two flip-flops; only the second is used. Entry
  // into reset is immediate, but the exit is retimed so that no flop sees
  // its reset end close to a clock edge.
  always @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Live results packed clear, red, green, blue from the low end, so that
  // a channel index times sixteen selects the low byte of that channel.
  assign live = {BLUE_DATA_I, GREEN_DATA_I, RED_DATA_I, CLEAR_DATA_I};

  // Read decodes. Each strobe lasts one cycle, so every side effect of a
  // read, such as a flag restart or a snapshot capture, happens once.
  assign rd_colour = REG_RD_I && in_colour(REG_ADDR_I);
  assign rd_lo     = rd_colour && !REG_ADDR_I[0];
  assign rd_clr_lo = REG_RD_I && (REG_ADDR_I == `SSDR_CLR_LO_ADDR);
  assign rd_prox   = REG_RD_I && (REG_ADDR_I == `SSDR_PROX_ADDR);
  assign rd_chan   = chan_of(REG_ADDR_I);

  // Gesture flag sources: level over threshold, or valid as mode falls.
  // Level and threshold are compared as unsigned counts.
  assign gest_set = (GESTURE_FIFO_LEVEL_I > GESTURE_FIFO_THRESHOLD_I) ||
                    (GESTURE_VALID_FLAG_I && mode_prev && !GESTURE_MODE_BIT_I);

  // Status image; threshold and burst flags are mirrored from their owners.
  // Mirroring means the host always sees their present state, and clearing
  // them stays with the unit that raised them.
  assign status = {clear_sat_flag,
                   prox_gest_sat_flag,
                   PROX_IRQ_FLAG_I,
                   LIGHT_IRQ_FLAG_I,
                   BURST_IRQ_FLAG_COPY_I,
                   gesture_irq_flag,
                   prox_valid_flag,
                   light_valid_flag};

  // Each flag except the two valid flags reaches the interrupt only through its own enable. The
  // enables gate only the interrupt, never the flag, so the host can still
  // poll a masked condition in the status register.
  assign irq_any =
    (status[`SSDR_CLR_SAT_BIT] && cfg2[`SSDR_CLEAR_SAT_IRQ_ENABLE_BIT]) ||
    (status[`SSDR_PG_SAT_BIT] && cfg2[`SSDR_PROX_SAT_IRQ_ENABLE_BIT]) ||
    (status[`SSDR_PROX_IRQ_BIT] && PROX_IRQ_ENABLE_I) ||
    (status[`SSDR_LIGHT_IRQ_BIT] && LIGHT_ENGINE_ENABLE_I) ||
    (status[`SSDR_BURST_IRQ_BIT] && BURST_IRQ_ENABLE_I) ||
    (status[`SSDR_GEST_IRQ_BIT] && GESTURE_IRQ_ENABLE_I);

  // The bus voltage strap is caught on the first clock after reset release,
  // because an asynchronous reset may only load constants.
  // A later change of the strap is ignored until the next reset.
  always @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      strap_done <= 1'b0;
      bus_1v8    <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      bus_1v8    <= BUS_1V8_I;
    end
  end

  // Saturation flags: an event in the clear cycle wins over the command,
  // but disabling the engine always clears since no event can follow.
  // A held event keeps its flag set for as long as it lasts.
  always @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      clear_sat_flag     <= 1'b0;
      prox_gest_sat_flag <= 1'b0;
    end else begin
      if (!LIGHT_ENGINE_ENABLE_I) begin
        clear_sat_flag <= 1'b0;
      end else if (CLEAR_SAT_EVENT_I) begin
        clear_sat_flag <= 1'b1;
      end else if (CLEAR_CHANNEL_IRQ_CLEAR_CMD_I) begin
        clear_sat_flag <= 1'b0;
      end
      // The proximity/gesture saturation flag follows the same scheme.
      if (!PROX_ENGINE_ENABLE_I) begin
        prox_gest_sat_flag <= 1'b0;
      end else if (PROX_SAT_EVENT_I) begin
        prox_gest_sat_flag <= 1'b1;
      end else if (PROX_IRQ_CLEAR_CMD_I) begin
        prox_gest_sat_flag <= 1'b0;
      end
    end
  end

  // Gesture flag: set wins over the FIFO-emptied clear. A new crossing in
  // the very cycle the host drains the FIFO must not be lost, or the host
  // would wait for an interrupt that never comes. The mode copy resets
  // low, so a reset taken with the mode high gives no false fall.
  always @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      gesture_irq_flag <= 1'b0;
      mode_prev        <= 1'b0;
    end else begin
      mode_prev <= GESTURE_MODE_BIT_I;
      if (gest_set) begin
        gesture_irq_flag <= 1'b1;
      end else if (GESTURE_FIFO_EMPTIED_I) begin
        gesture_irq_flag <= 1'b0;
      end
    end
  end

  // Valid flags: a cycle completing in the read cycle keeps the flag set,
  // so no result is reported as stale when it is in fact fresh.
  // Disabling an engine drops its valid flag, so a re-enable starts fresh.
  always @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      prox_valid_flag  <= 1'b0;
      light_valid_flag <= 1'b0;
    end else begin
      if (!PROX_ENGINE_ENABLE_I) begin
        prox_valid_flag <= 1'b0;
      end else if (PROX_CYCLE_DONE_I) begin
        prox_valid_flag <= 1'b1;
      end else if (rd_prox) begin
        prox_valid_flag <= 1'b0;
      end
      if (!LIGHT_ENGINE_ENABLE_I) begin
        light_valid_flag <= 1'b0;
      end else if (LIGHT_CYCLE_DONE_I) begin
        light_valid_flag <= 1'b1;
      end else if (rd_colour) begin
        light_valid_flag <= 1'b0;
      end
    end
  end

  // Writable registers; every other address ignores writes. Read-only
  // registers have no write path at all, so a stray write cannot disturb
  // a flag or a result.
  always @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      cfg2              <= `SSDR_CFG2_RST;
      north_east_offset <= 8'h00;
    end else if (REG_WR_I) begin
      case (REG_ADDR_I)
        `SSDR_CFG2_ADDR: begin
          cfg2 <= REG_WDATA_I;
        end
        `SSDR_NE_OFS_ADDR: begin
          north_east_offset <= REG_WDATA_I;
        end
        default: begin
          // Writes to any other address, read-only ones included, do nothing.
          cfg2 <= cfg2;
        end
      endcase
    end
  end

  // Colour snapshot. A clear low read freezes all four channels and locks
  // the set until the blue high byte is read; outside a locked set a low
  // read captures only its own high byte. The host must keep the pair
  // order, since a stray high read returns whatever was last captured.
  // The lock costs one flop; the price is that an abandoned set stays
  // frozen until the blue high byte or a new clear low byte is read.
  always @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      snap       <= 64'h0000000000000000;
      set_locked <= 1'b0;
    end else begin
      if (rd_clr_lo) begin
        snap       <= live;
        set_locked <= 1'b1;
      end else if (rd_lo && !set_locked) begin
        snap[rd_chan*16+8 +: 8] <= live[rd_chan*16+8 +: 8];
      end else if (REG_RD_I && REG_ADDR_I == `SSDR_BLU_HI_ADDR) begin
        // The blue high byte ends a coherent set.
        set_locked <= 1'b0;
      end
    end
  end

  // Read multiplexer. It decodes the address alone and is loaded into the
  // output register only on a read strobe, so the address may move freely
  // between accesses. Unmapped addresses read as zero.
  always @* begin
    next_rdata = 8'h00;
    case (REG_ADDR_I)
      `SSDR_CFG2_ADDR: begin
        next_rdata = cfg2;
      end
      `SSDR_REV_ADDR: begin
        next_rdata = {`SSDR_REV_RSVD, DIE_REV};
      end
      `SSDR_ID_ADDR: begin
        next_rdata = {DEV_ID_CODE, bus_1v8 ? `SSDR_VID_1V8 : `SSDR_VID_CORE};
      end
      `SSDR_STATUS_ADDR: begin
        next_rdata = status;
      end
      `SSDR_CLR_LO_ADDR: begin
        next_rdata = CLEAR_DATA_I[7:0];
      end
      `SSDR_PROX_ADDR: begin
        next_rdata = PROXIMITY_RESULT_I;
      end
      `SSDR_NE_OFS_ADDR: begin
        next_rdata = north_east_offset;
      end
      default: begin
        // High bytes and locked low bytes come from the snapshot.
        if (in_colour(REG_ADDR_I)) begin
          if (REG_ADDR_I[0] || set_locked) begin
            next_rdata = snap[rd_chan*16 + (REG_ADDR_I[0] ? 8 : 0) +: 8];
          end else begin
            next_rdata = live[rd_chan*16 +: 8];
          end
        end
      end
    endcase
  end

  // Registered outputs. Read data holds until the next read, while the
  // valid pulse lasts one cycle; the host must take the data with it.
  // The correction and the interrupt lag their causes by one cycle, and
  // all outputs clear together on reset so the interrupt cannot glitch.
  always @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      REG_RDATA_O     <= 8'h00;
      REG_RVALID_O    <= 1'b0;
      NE_CORRECTION_O <= 8'h00;
      INT_O           <= 1'b0;
    end else begin
      REG_RVALID_O    <= REG_RD_I;
      if (REG_RD_I) begin
        REG_RDATA_O <= next_rdata;
      end
      NE_CORRECTION_O <= sm_to_tc(north_east_offset);
      INT_O           <= irq_any;
    end
  end

endmodule

// ### verif/ssdr_host_model.sv
`timescale 1ns/10ps
// Register host: one-cycle strobes launched on the falling edge.
module ssdr_host_model (
  input  wire       clk_i,    // Clock.
  input  wire [7:0] rdata_i,  // Read data.
  input  wire       rvalid_i, // Read valid.
  output reg  [7:0] addr_o,   // Address.
  output reg        rd_o,     // Read strobe.
  output reg        wr_o,     // Write strobe.
  output reg  [7:0] wdata_o   // Write data.
);
  // Idle values at time zero.
  initial begin
    addr_o = 8'h00;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 8'h00;
  end
  // Released address and data lines show the inverse of the last value, so a stale copy cannot pass.
  task automatic drive(input logic r, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    rd_o = r;
    wr_o = !r;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    drive(1'b0, a, d);
  endtask
  // A missing valid pulse yields unknown data, which never matches.
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    drive(1'b1, a, 8'h00);
    q = rvalid_i ? rdata_i : 8'hxx;
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] q);
    rd(a, q[7:0]);
    rd(a + 8'h01, q[15:8]);
  endtask
endmodule

// ### verif/ssdr_regs_props.sv
`timescale 1ns/10ps
// Port-level checks; a read is answered on the edge after its strobe.
module ssdr_regs_props #(
  parameter [5:0] DEV_ID_CODE = 6'h2a, // Arbitrary identification value.
  parameter [2:0] DIE_REV     = 3'h1   // Arbitrary revision value.
) (
  input wire       SYS_CLK_I,             // Clock.
  input wire       RST_N_I,               // Reset, active low.
  input wire [7:0] REG_ADDR_I,            // Address.
  input wire       REG_RD_I,              // Read strobe.
  input wire       REG_WR_I,              // Write strobe.
  input wire [7:0] REG_WDATA_I,           // Write data.
  input wire [7:0] REG_RDATA_O,           // Read data.
  input wire       BUS_1V8_I,             // Bus voltage strap.
  input wire       CLEAR_SAT_EVENT_I,     // Clear saturation.
  input wire       PROX_SAT_EVENT_I,      // Proximity saturation.
  input wire       LIGHT_ENGINE_ENABLE_I, // Light enable.
  input wire       PROX_ENGINE_ENABLE_I,  // Proximity enable.
  input wire       PROX_IRQ_ENABLE_I,     // Proximity irq enable.
  input wire       BURST_IRQ_ENABLE_I,    // Burst irq enable.
  input wire       GESTURE_IRQ_ENABLE_I,  // Gesture irq enable.
  input wire [7:0] PROXIMITY_RESULT_I,    // Proximity result.
  input wire [7:0] NE_CORRECTION_O,       // Offset correction.
  input wire       INT_O                  // Interrupt.
);
  // Negative zero folds to zero, so both encodings of zero give no correction.
  function automatic logic [7:0] sm_to_tc(input logic [7:0] v);
    return v[7] ? 8'h00 - {1'b0, v[6:0]} : {1'b0, v[6:0]};
  endfunction
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  property p_rev; REG_RD_I && REG_ADDR_I == 8'h91 |=> REG_RDATA_O == {5'h00, DIE_REV}; endproperty
  a_rev: assert property (p_rev) else $error("revision read wrong");
  property p_id; REG_RD_I && REG_ADDR_I == 8'h92 |=> REG_RDATA_O[7:2] == DEV_ID_CODE; endproperty
  a_id: assert property (p_id) else $error("identification code wrong");
  property p_vid; REG_RD_I && REG_ADDR_I == 8'h92
    |=> REG_RDATA_O[1:0] == {$past(BUS_1V8_I), 1'b0}; endproperty
  a_vid: assert property (p_vid) else $error("bus voltage field wrong");
  property p_prox; REG_RD_I && REG_ADDR_I == 8'h9c
    |=> REG_RDATA_O == $past(PROXIMITY_RESULT_I); endproperty
  a_prox: assert property (p_prox) else $error("proximity read wrong");
  property p_ne; REG_WR_I && REG_ADDR_I == 8'h9d
    |=> ##1 NE_CORRECTION_O == sm_to_tc($past(REG_WDATA_I, 2)); endproperty
  a_ne: assert property (p_ne) else $error("offset correction wrong");
  property p_quiet; (!LIGHT_ENGINE_ENABLE_I && !PROX_ENGINE_ENABLE_I && !PROX_IRQ_ENABLE_I &&
    !BURST_IRQ_ENABLE_I && !GESTURE_IRQ_ENABLE_I && !CLEAR_SAT_EVENT_I && !PROX_SAT_EVENT_I)[*3]
    |=> !INT_O; endproperty
  a_quiet: assert property (p_quiet) else $error("interrupt without enable");
  property p_csat; (CLEAR_SAT_EVENT_I && LIGHT_ENGINE_ENABLE_I) ##1 (REG_RD_I &&
    REG_ADDR_I == 8'h93 && LIGHT_ENGINE_ENABLE_I) |=> REG_RDATA_O[7]; endproperty
  a_csat: assert property (p_csat) else $error("clear saturation not seen");
  property p_psat; (PROX_SAT_EVENT_I && PROX_ENGINE_ENABLE_I) ##1 (REG_RD_I &&
    REG_ADDR_I == 8'h93 && PROX_ENGINE_ENABLE_I) |=> REG_RDATA_O[6]; endproperty
  a_psat: assert property (p_psat) else $error("proximity saturation not seen");
endmodule
bind ssdr_regs ssdr_regs_props #(.DEV_ID_CODE(DEV_ID_CODE), .DIE_REV(DIE_REV)) i_ssdr_regs_props (
  .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .REG_ADDR_I(REG_ADDR_I), .REG_RD_I(REG_RD_I),
  .REG_WR_I(REG_WR_I), .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
  .BUS_1V8_I(BUS_1V8_I), .CLEAR_SAT_EVENT_I(CLEAR_SAT_EVENT_I),
  .PROX_SAT_EVENT_I(PROX_SAT_EVENT_I), .LIGHT_ENGINE_ENABLE_I(LIGHT_ENGINE_ENABLE_I),
  .PROX_ENGINE_ENABLE_I(PROX_ENGINE_ENABLE_I), .PROX_IRQ_ENABLE_I(PROX_IRQ_ENABLE_I),
  .BURST_IRQ_ENABLE_I(BURST_IRQ_ENABLE_I), .GESTURE_IRQ_ENABLE_I(GESTURE_IRQ_ENABLE_I),
  .PROXIMITY_RESULT_I(PROXIMITY_RESULT_I), .NE_CORRECTION_O(NE_CORRECTION_O), .INT_O(INT_O));

// ### verif/ssdr_regs_tb.sv
`timescale 1ns/10ps
module ssdr_regs_tb;
  localparam [5:0] DEV = 6'h15; // Arbitrary identification value.
  localparam [2:0] REV = 3'h5;  // Arbitrary revision value.
  localparam int CE = 0, PS = 1, CC = 2, PC = 3, GE = 4, PD = 5, LD = 6;
  logic        clk, rst_n, bus18, le, prox_engine_enable, pie, bie, gie, pf, lf, bf, gv, gm, rd, wr, rvalid, irq;
  logic [6:0]  pl;
  logic [5:0]  glev, gth;
  logic [7:0]  pr, addr, wdata, rdata, ne, q;
  logic [15:0] q16;
  logic [15:0] col [4];
  logic [15:0] old [4];
  logic [15:0] ne_tab [7] = '{16'h7f7f, 16'h0101, 16'h0000, 16'h81ff,
                              16'h82fe, 16'hff81, 16'h8000};
  int          n_errors = 0;
  int          tests_run = 0;
  ssdr_regs #(.DEV_ID_CODE(DEV), .DIE_REV(REV)) i_ssdr_regs (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_RD_I(rd), .REG_WR_I(wr),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .BUS_1V8_I(bus18),
    .CLEAR_SAT_EVENT_I(pl[CE]), .PROX_SAT_EVENT_I(pl[PS]),
    .CLEAR_CHANNEL_IRQ_CLEAR_CMD_I(pl[CC]), .PROX_IRQ_CLEAR_CMD_I(pl[PC]),
    .LIGHT_ENGINE_ENABLE_I(le), .PROX_ENGINE_ENABLE_I(prox_engine_enable), .PROX_IRQ_ENABLE_I(pie),
    .BURST_IRQ_ENABLE_I(bie), .GESTURE_IRQ_ENABLE_I(gie), .PROX_IRQ_FLAG_I(pf),
    .LIGHT_IRQ_FLAG_I(lf), .BURST_IRQ_FLAG_COPY_I(bf), .GESTURE_FIFO_LEVEL_I(glev),
    .GESTURE_FIFO_THRESHOLD_I(gth), .GESTURE_VALID_FLAG_I(gv), .GESTURE_MODE_BIT_I(gm),
    .GESTURE_FIFO_EMPTIED_I(pl[GE]), .PROX_CYCLE_DONE_I(pl[PD]), .LIGHT_CYCLE_DONE_I(pl[LD]),
    .CLEAR_DATA_I(col[0]), .RED_DATA_I(col[1]), .GREEN_DATA_I(col[2]), .BLUE_DATA_I(col[3]),
    .PROXIMITY_RESULT_I(pr), .NE_CORRECTION_O(ne), .INT_O(irq));
  ssdr_host_model i_ssdr_host_model (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid),
    .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata));
  // Free-running clock, 4 ns period.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    i_ssdr_host_model.rd(a, q);
    chk($sformatf("register %h", a), {8'h00, exp}, {8'h00, q});
  endtask
  task automatic pulse(input int b);
    @(negedge clk);
    pl[b] = 1'b1;
    @(negedge clk);
    pl[b] = 1'b0;
  endtask
  // Keeps the event up so the status read lands on the edge right after it.
  task automatic ev_read(input int b, input logic [7:0] exp);
    @(negedge clk);
    pl[b] = 1'b1;
    rchk(8'h93, exp);
    pl[b] = 1'b0;
  endtask
  task automatic ck_irq(input logic e);
    tick(3);
    chk("interrupt", {15'h0000, e}, {15'h0000, irq});
  endtask
  task automatic do_reset(input logic strap);
    rst_n = 1'b0;
    bus18 = strap;
    tick(20);
    rst_n = 1'b1;
    tick(4);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // The run takes a few hundred cycles; 25000 leaves a wide margin.
  initial begin
    #100000;
    n_errors++;
    close_out();
  end
  // Main sequence.
  initial begin
    {rst_n, bus18, le, prox_engine_enable, pie, bie, gie, pf, lf, bf, gv, gm} = 12'h000;
    pl = 7'h00;
    glev = 6'h00;
    gth = 6'h10;
    pr = 8'hc3;
    col = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0};
    do_reset(1'b0);
    rchk(8'h91, {5'h00, REV});
    rchk(8'h92, {DEV, 2'b00});
    i_ssdr_host_model.wr(8'h91, 8'hff);
    i_ssdr_host_model.wr(8'h92, 8'h01);
    i_ssdr_host_model.wr(8'h9c, 8'h00);
    rchk(8'h91, {5'h00, REV});
    rchk(8'h92, {DEV, 2'b00});
    rchk(8'h9c, pr);
    $display("test identification done");
    {pf, lf, bf} = 3'b111;
    for (int k = 0; k < 4; k++) begin
      {le, bie, pie} = (k == 0) ? 3'b000 : 3'b001 << (k - 1);
      ck_irq(k != 0);
    end
    le = 1'b0;
    i_ssdr_host_model.wr(8'h93, 8'hc7);
    rchk(8'h93, 8'h38);
    {pf, lf, bf} = 3'b000;
    $display("test mirrored flags done");
    {le, prox_engine_enable} = 2'b11;
    i_ssdr_host_model.wr(8'h90, 8'h41);
    rchk(8'h90, 8'h41);
    ev_read(CE, 8'h80);
    ck_irq(1'b1);
    ev_read(PS, 8'hc0);
    pulse(CC);
    rchk(8'h93, 8'h40);
    ck_irq(1'b0);
    i_ssdr_host_model.wr(8'h90, 8'h81);
    ck_irq(1'b1);
    pulse(PC);
    rchk(8'h93, 8'h00);
    ev_read(CE, 8'h80);
    ck_irq(1'b0);
    ev_read(PS, 8'hc0);
    {le, prox_engine_enable} = 2'b00;
    rchk(8'h93, 8'h00);
    $display("test saturation done");
    {le, prox_engine_enable} = 2'b11;
    pulse(PD);
    rchk(8'h93, 8'h02);
    rchk(8'h9c, pr);
    rchk(8'h93, 8'h00);
    pulse(LD);
    rchk(8'h93, 8'h01);
    rchk(8'h96, col[1][7:0]);
    rchk(8'h93, 8'h00);
    {le, prox_engine_enable} = 2'b00;
    $display("test valid flags done");
    glev = 6'h10;
    rchk(8'h93, 8'h00);
    glev = 6'h11;
    tick(2);
    glev = 6'h00;
    rchk(8'h93, 8'h04);
    gie = 1'b1;
    ck_irq(1'b1);
    gie = 1'b0;
    pulse(GE);
    rchk(8'h93, 8'h00);
    gm = 1'b1;
    tick(2);
    {gv, gm} = 2'b10;
    tick(2);
    gv = 1'b0;
    rchk(8'h93, 8'h04);
    pulse(GE);
    rchk(8'h93, 8'h00);
    $display("test gesture done");
    i_ssdr_host_model.rd16(8'h94, q16);
    chk("clear pair", col[0], q16);
    old = col;
    for (int k = 0; k < 4; k++)
      col[k] = ~col[k];
    for (int k = 1; k < 4; k++) begin
      i_ssdr_host_model.rd16(8'h94 + 8'(2 * k), q16);
      chk("colour pair", old[k], q16);
    end
    rchk(8'h96, col[1][7:0]);
    col[1] = 16'h4321;
    rchk(8'h97, ~old[1][15:8]);
    $display("test colour done");
    foreach (ne_tab[k]) begin
      i_ssdr_host_model.wr(8'h9d, ne_tab[k][15:8]);
      tick(2);
      chk("offset correction", {8'h00, ne_tab[k][7:0]}, {8'h00, ne});
      rchk(8'h9d, ne_tab[k][15:8]);
    end
    $display("test offset done");
    do_reset(1'b1);
    rchk(8'h92, {DEV, 2'b10});
    $display("test strap done");
    close_out();
  end
endmodule
